// ### dv/fmsd_panel_model.sv
// behavioural two-digit display and bicolour indicator that logs what it shows
`timescale 1ns/1ps
`default_nettype none
module fmsd_panel_model (
   input wire logic       aclk,
   input wire logic [7:0] disp_code,
   input wire logic       led_green,
   input wire logic       led_red
);
   logic [7:0] codes[$];
   int         lens[$];
   int         cnt      = 0;
   int         led_cnt  = 0;
   int         led_len  = 0;
   int         led_n    = 0;
   logic [7:0] last     = 8'h00;
   logic [1:0] led_last = 2'h0;
   // each shown code and how many cycles it stood
   always @(posedge aclk) begin
      if (disp_code !== last) begin
         if (codes.size() > 0) lens.push_back(cnt);
         codes.push_back(disp_code);
         cnt = 1;
      end else cnt++;
      last = disp_code;
      // lamp toggle spacing
      if ({led_green, led_red} !== led_last) begin
         led_len = led_cnt;
         led_n++;
         led_cnt = 1;
      end else led_cnt++;
      led_last = {led_green, led_red};
   end
endmodule : fmsd_panel_model
`default_nettype wire

// ### dv/tb_fieldbus_master_status_display.sv
// self-checking bench for the status display block
`timescale 1ns/1ps
`default_nettype none
module tb_fieldbus_master_status_display;
   localparam int HOLD  = 8;
   localparam int FLASH = 4;
   localparam logic [7:0] CODE [10] = '{8'he6, 8'hfb, 8'hf2, 8'hf1, 8'hf5,
                                        8'hf8, 8'hf4, 8'hf3, 8'hf6, 8'hf7};
   logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic [3:0]  awaddr = 4'h0, araddr = 4'h0, wstrb = 4'h0;
   logic [31:0] wdata = 32'h0, rdata, d;
   logic [1:0]  bresp, rresp, r;
   logic        awready, wready, bvalid, arready, rvalid, led_green, led_red, irq;
   logic        plc_run = 1'b1;
   logic [7:0]  disp_code, node, s2;
   logic [127:0] cfg = 128'h0, off = 128'h0;
   fmsd_pkg::fmsd_fault_t fault = '0;
   int error_cnt = 0, samples_checked = 0;

   fmsd_top #(.HOLD_CYC(HOLD), .FLASH_CYC(FLASH)) fmsd_top_i (.aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .plc_run(plc_run), .fault(fault), .cfg_slave_map(cfg), .offline_map(off),
      .disp_code(disp_code), .led_green(led_green), .led_red(led_red), .irq(irq));
   fmsd_panel_model fmsd_panel_model_i (.aclk(aclk), .disp_code(disp_code),
      .led_green(led_green), .led_red(led_red));

   initial forever #50 aclk = ~aclk;

   task automatic stop_test();
      $display("checks %0d errors %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : stop_test

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      samples_checked++;
      if (g !== e) begin
         error_cnt++;
         $display("unexpected %s: expected %h seen %h", nm, e, g);
      end
   endtask : chk

   task automatic wr(input logic [3:0] a, input logic [31:0] v);
      int n;
      n = 0;
      awaddr <= a; wdata <= v; wstrb <= 4'hf; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         n++;
      end while (bvalid !== 1'b1 && n < 50);
      bready <= 1'b0;
      chk("bresp", 32'h0, {30'h0, bresp});
      @(posedge aclk);
   endtask : wr

   task automatic rd(input logic [3:0] a, output logic [31:0] v, output logic [1:0] rs);
      int n;
      n = 0;
      araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (arvalid && arready) arvalid <= 1'b0;
         n++;
      end while (rvalid !== 1'b1 && n < 50);
      v = rdata;
      rs = rresp;
      rready <= 1'b0;
      chk("rvalid", 32'h1, {31'h0, rvalid});
      @(posedge aclk);
   endtask : rd

   function automatic logic [7:0] top_code(input logic [9:0] f);
      for (int i = 9; i >= 0; i--) if (f[i]) return CODE[i];
      return node;
   endfunction : top_code

   task automatic clr(input int cyc);
      @(negedge aclk);
      fmsd_panel_model_i.codes.delete();
      fmsd_panel_model_i.lens.delete();
      fmsd_panel_model_i.led_n = 0;
      repeat (cyc) @(posedge aclk);
   endtask : clr

   // compare the logged display cycle with the expected repeating list
   task automatic seq(input logic [7:0] e[$]);
      clr(2 * e.size() * HOLD + 4);
      for (int i = 0; i < fmsd_panel_model_i.lens.size(); i++) begin
         chk("code", e[i % e.size()], fmsd_panel_model_i.codes[i]);
         if (i > 0) chk("hold", HOLD, fmsd_panel_model_i.lens[i]);
      end
      chk("runs", 1, fmsd_panel_model_i.lens.size() > e.size());
      plc_run <= 1'b1;
      off <= 128'h0;
      repeat (3) @(posedge aclk);
   endtask : seq

   initial begin
      #(100 * 6000);
      error_cnt++;
      stop_test();
   end

   initial begin
      logic [9:0] v;
      void'($urandom(783));
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      rd(4'h0, d, r);
      chk("node reset", 32'h1, {25'h0, d[6:0]});
      node = 8'($urandom_range(125, 0));
      s2 = 8'($urandom_range(120, 6));
      cfg <= (128'h1 << 2) | (128'h1 << s2) | (128'h1 << 5);
      wr(4'h0, {24'h0, node});
      clr(40);
      chk("node", node, disp_code);
      chk("changes", 0, fmsd_panel_model_i.codes.size());
      chk("green steady", 32'h2, {30'h0, led_green, led_red});
      chk("led changes", 0, fmsd_panel_model_i.led_n);
      for (int k = 0; k < 30; k++) begin
         v = (k < 10) ? 10'h1 << k : 10'($urandom_range(1023, 1));
         fault <= v;
         repeat (3) @(posedge aclk);
         chk("fault code", top_code(v), disp_code);
      end
      fault <= '0;
      plc_run <= 1'b0;
      seq('{8'h80, node});
      off <= (128'h1 << 2) | (128'h1 << s2);
      seq('{8'he2, 8'h02, 8'he2, s2});
      off <= (128'h1 << 2) | (128'h1 << s2);
      clr(12);
      chk("red flash", FLASH, fmsd_panel_model_i.led_len);
      chk("green off", 0, led_green);
      fault.no_map <= 1'b1;
      repeat (3) @(posedge aclk);
      chk("f2 hidden", 0, disp_code === 8'hf2);
      fault <= '0;
      plc_run <= 1'b0;
      seq('{8'h80, node, 8'he2, 8'h02, 8'h80, node, 8'he2, s2});
      off <= cfg;
      repeat (3) @(posedge aclk);
      clr(12);
      chk("red steady", 32'h1, {30'h0, led_green, led_red});
      chk("led changes", 0, fmsd_panel_model_i.led_n);
      off <= 128'h0;
      fault.cfg_empty <= 1'b1;
      clr(14);
      chk("empty code", 8'hf1, disp_code);
      chk("green flash", FLASH, fmsd_panel_model_i.led_len);
      chk("red off", 0, led_red);
      fault <= '0;
      wr(4'hc, 32'h7);
      wr(4'h8, 32'h7);
      chk("irq clear", 0, irq);
      fault.storage <= 1'b1;
      repeat (3) @(posedge aclk);
      chk("irq set", 1, irq);
      rd(4'h8, d, r);
      chk("irq stat", 1, d[0]);
      fault <= '0;
      wr(4'h8, 32'h1);
      chk("irq w1c", 0, irq);
      wr(4'hc, 32'h0);
      fault.storage <= 1'b1;
      repeat (3) @(posedge aclk);
      chk("irq masked", 0, irq);
      rd(4'h4, d, r);
      chk("status code", 8'hf6, d[7:0]);
      rd(4'h2, d, r);
      chk("unaligned resp", 32'h3, {30'h0, r});
      chk("unaligned data", 32'h0, d);
      stop_test();
   end
endmodule : tb_fieldbus_master_status_display
`default_nettype wire

// ### hw/fmsd_cfg.svh
// constants for the fieldbus master status display block
`ifndef FMSD_CFG_SVH
`define FMSD_CFG_SVH
`define FMSD_CLK_NS        100
`define FMSD_HOLD_MS       1000
`define FMSD_FLASH_HALF_MS 250
`define FMSD_HOLD_CYC      (`FMSD_HOLD_MS * 1000000 / `FMSD_CLK_NS)
`define FMSD_FLASH_CYC     (`FMSD_FLASH_HALF_MS * 1000000 / `FMSD_CLK_NS)
`define FMSD_CODE_STOP     8'h80
`define FMSD_CODE_E2       8'he2
`define FMSD_CODE_E6       8'he6
`define FMSD_CODE_F1       8'hf1
`define FMSD_CODE_F2       8'hf2
`define FMSD_CODE_F3       8'hf3
`define FMSD_CODE_F4       8'hf4
`define FMSD_CODE_F5       8'hf5
`define FMSD_CODE_F6       8'hf6
`define FMSD_CODE_F7       8'hf7
`define FMSD_CODE_F8       8'hf8
`define FMSD_CODE_FB       8'hfb
`define FMSD_OFF_CTRL      4'h0
`define FMSD_OFF_STATUS    4'h4
`define FMSD_OFF_IRQ_STAT  4'h8
`define FMSD_OFF_IRQ_MASK  4'hc
`define FMSD_NODE_RST      7'h01
`define FMSD_IRQ_W         3
`define FMSD_IRQ_ERR       0
`define FMSD_IRQ_OFF       1
`define FMSD_IRQ_ALL       2
`define FMSD_ST_GREEN      8
`define FMSD_ST_RED        9
`define FMSD_ST_ERR        10
`define FMSD_ST_SEQ        11
`endif

// ### hw/fmsd_pkg.sv
// types for the fieldbus master status display block
package fmsd_pkg;
   typedef struct packed {
      logic dx_unit;
      logic storage;
      logic test_mode;
      logic init_fail;
      logic serial_fail;
      logic chip_timeout;
      logic cfg_empty;
      logic no_map;
      logic plc_timeout;
      logic rtu_fault;
   } fmsd_fault_t;
   typedef enum logic [3:0] {
      PH_STOP = 4'b0001,
      PH_OWN  = 4'b0010,
      PH_E2   = 4'b0100,
      PH_SLV  = 4'b1000
   } fmsd_phase_t;
endpackage : fmsd_pkg

// ### hw/fmsd_top.sv
// status indicator and two-digit display logic with axi4-lite registers
`timescale 1ns/1ps
`default_nettype none
`include "fmsd_cfg.svh"
module fmsd_top #(
   parameter int HOLD_CYC  = `FMSD_HOLD_CYC,
   parameter int FLASH_CYC = `FMSD_FLASH_CYC,
   parameter int CNT_W     = 24
) (
   input  wire logic                aclk,
   input  wire logic                aresetn,
   input  wire logic [3:0]          s_axi_awaddr,
   input  wire logic                s_axi_awvalid,
   output logic                     s_axi_awready,
   input  wire logic [31:0]         s_axi_wdata,
   input  wire logic [3:0]          s_axi_wstrb,
   input  wire logic                s_axi_wvalid,
   output logic                     s_axi_wready,
   output logic [1:0]               s_axi_bresp,
   output logic                     s_axi_bvalid,
   input  wire logic                s_axi_bready,
   input  wire logic [3:0]          s_axi_araddr,
   input  wire logic                s_axi_arvalid,
   output logic                     s_axi_arready,
   output logic [31:0]              s_axi_rdata,
   output logic [1:0]               s_axi_rresp,
   output logic                     s_axi_rvalid,
   input  wire logic                s_axi_rready,
   input  wire logic                plc_run,
   input  wire fmsd_pkg::fmsd_fault_t fault,
   input  wire logic [127:0]        cfg_slave_map,
   input  wire logic [127:0]        offline_map,
   output logic [7:0]               disp_code,
   output logic                     led_green,
   output logic                     led_red,
   output logic                     irq
);
   // first set bit at or after start, with wrap
   function automatic logic [6:0] find_next(input logic [127:0] v, input logic [6:0] s);
      logic [6:0] idx;
      logic       hit;
      find_next = s;
      hit = 1'b0;
      for (int i = 0; i < 128; i++) begin
         idx = s + 7'(i);
         if (!hit && v[idx]) begin
            find_next = idx;
            hit = 1'b1;
         end
      end
   endfunction : find_next

   logic [6:0]               node_q;
   logic [`FMSD_IRQ_W-1:0]   irq_stat_q, irq_stat_d, irq_mask_q;
   logic [7:0]               disp_q, disp_d;
   logic                     green_q, red_q, flash_q;
   logic [CNT_W-1:0]         hold_q, flash_cnt_q;
   fmsd_pkg::fmsd_phase_t    phase_q, phase_d;
   logic [6:0]               ptr_q;
   logic                     mode_run_q, seq_q, err_q, off_q, all_q;
   logic                     aw_held_q, w_held_q, bvalid_q, rvalid_q;
   logic [3:0]               awaddr_q;
   logic [31:0]              wdata_q, rdata_q;
   logic [3:0]               wstrb_q;
   logic [1:0]               bresp_q, rresp_q;

   // condition decode
   wire [127:0] off_v    = offline_map & cfg_slave_map;
   wire         any_off  = |off_v;
   wire         all_off  = (cfg_slave_map != 128'h0) && (off_v == cfg_slave_map);
   wire         hi_fault = fault.dx_unit | fault.storage | fault.test_mode | fault.init_fail
                           | fault.serial_fail | fault.chip_timeout | fault.cfg_empty;
   wire         lo_fault = fault.no_map | fault.plc_timeout | fault.rtu_fault;
   wire         err_now  = hi_fault | lo_fault;
   wire         seq_mode = !hi_fault && (any_off || !plc_run);
   wire [7:0]   node_code = {1'b0, node_q};
   wire [6:0]   slave_idx = find_next(off_v, ptr_q);

   // any change of mode or of whether any slave is offline starts the sequence over
   wire restart  = (seq_mode != seq_q) || (plc_run != mode_run_q) || (any_off != off_q);
   wire fmsd_pkg::fmsd_phase_t start_ph = plc_run ? fmsd_pkg::PH_E2 : fmsd_pkg::PH_STOP;
   // phase in force this cycle: the first code of a new sequence shows at once
   wire fmsd_pkg::fmsd_phase_t cur_ph   = (restart || !seq_mode) ? start_ph : phase_q;

   wire [7:0] hi_code =
      fault.dx_unit      ? `FMSD_CODE_F7 :
      fault.storage      ? `FMSD_CODE_F6 :
      fault.test_mode    ? `FMSD_CODE_F3 :
      fault.init_fail    ? `FMSD_CODE_F4 :
      fault.serial_fail  ? `FMSD_CODE_F8 :
      fault.chip_timeout ? `FMSD_CODE_F5 : `FMSD_CODE_F1;
   wire [7:0] lo_code =
      fault.no_map       ? `FMSD_CODE_F2 :
      fault.plc_timeout  ? `FMSD_CODE_FB :
      fault.rtu_fault    ? `FMSD_CODE_E6 : node_code;

   always_comb begin
      case (cur_ph)
         fmsd_pkg::PH_STOP: disp_d = `FMSD_CODE_STOP;
         fmsd_pkg::PH_OWN:  disp_d = node_code;
         fmsd_pkg::PH_E2:   disp_d = `FMSD_CODE_E2;
         fmsd_pkg::PH_SLV:  disp_d = {1'b0, slave_idx};
         default:           disp_d = node_code;
      endcase
      if (hi_fault)
         disp_d = hi_code;
      else if (!seq_mode)
         disp_d = lo_code;
   end

   // sequence step: stop-only 80/own, run-offline E2/slave, stop-offline all four
   always_comb begin
      case (phase_q)
         fmsd_pkg::PH_STOP: phase_d = fmsd_pkg::PH_OWN;
         fmsd_pkg::PH_OWN:  phase_d = any_off ? fmsd_pkg::PH_E2 : fmsd_pkg::PH_STOP;
         fmsd_pkg::PH_E2:   phase_d = fmsd_pkg::PH_SLV;
         fmsd_pkg::PH_SLV:  phase_d = plc_run ? fmsd_pkg::PH_E2 : fmsd_pkg::PH_STOP;
         default:           phase_d = fmsd_pkg::PH_STOP;
      endcase
   end

   wire hold_end = (hold_q == '0);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         phase_q    <= fmsd_pkg::PH_STOP;
         hold_q     <= '0;
         ptr_q      <= 7'h00;
         seq_q      <= 1'b0;
         mode_run_q <= 1'b0;
         disp_q     <= 8'h00;
      end else begin
         seq_q      <= seq_mode;
         mode_run_q <= plc_run;
         disp_q     <= disp_d;
         if (restart || !seq_mode) begin
            phase_q <= start_ph;
            hold_q  <= CNT_W'(HOLD_CYC - 1);
            ptr_q   <= 7'h00;
         end else if (hold_end) begin
            phase_q <= phase_d;
            hold_q  <= CNT_W'(HOLD_CYC - 1);
            if (phase_q == fmsd_pkg::PH_SLV)
               ptr_q <= slave_idx + 7'h01;
         end else begin
            hold_q <= hold_q - CNT_W'(1);
         end
      end
   end

   // indicator
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         flash_cnt_q <= '0;
         flash_q     <= 1'b0;
         green_q     <= 1'b0;
         red_q       <= 1'b0;
      end else begin
         if (flash_cnt_q == '0) begin
            flash_cnt_q <= CNT_W'(FLASH_CYC - 1);
            flash_q     <= !flash_q;
         end else begin
            flash_cnt_q <= flash_cnt_q - CNT_W'(1);
         end
         if (fault.cfg_empty) begin
            green_q <= flash_q;
            red_q   <= 1'b0;
         end else if (all_off) begin
            green_q <= 1'b0;
            red_q   <= 1'b1;
         end else if (any_off) begin
            green_q <= 1'b0;
            red_q   <= flash_q;
         end else begin
            green_q <= 1'b1;
            red_q   <= 1'b0;
         end
      end
   end

   // axi4-lite slave
   wire wr_go   = aw_held_q && w_held_q && !bvalid_q;
   wire ar_go   = s_axi_arvalid && !rvalid_q;
   wire wr_ctrl = wr_go && (awaddr_q == `FMSD_OFF_CTRL) && wstrb_q[0];
   wire wr_stat = wr_go && (awaddr_q == `FMSD_OFF_IRQ_STAT) && wstrb_q[0];
   wire wr_mask = wr_go && (awaddr_q == `FMSD_OFF_IRQ_MASK) && wstrb_q[0];
   wire [`FMSD_IRQ_W-1:0] irq_ev = {all_off & !all_q, any_off & !off_q, err_now & !err_q};
   wire [31:0] status_w = {20'h0, seq_mode, err_now, red_q, green_q, disp_q};
   wire addr_ok_w = (awaddr_q[1:0] == 2'b00);
   wire addr_ok_r = (s_axi_araddr[1:0] == 2'b00);

   // set wins over write-one-to-clear
   assign irq_stat_d = (irq_stat_q & ~(wr_stat ? wdata_q[`FMSD_IRQ_W-1:0] : '0)) | irq_ev;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_q  <= 1'b0;
         w_held_q   <= 1'b0;
         bvalid_q   <= 1'b0;
         rvalid_q   <= 1'b0;
         awaddr_q   <= 4'h0;
         wdata_q    <= 32'h0;
         wstrb_q    <= 4'h0;
         bresp_q    <= 2'b00;
         rresp_q    <= 2'b00;
         rdata_q    <= 32'h0;
         node_q     <= `FMSD_NODE_RST;
         irq_mask_q <= '0;
         irq_stat_q <= '0;
         err_q      <= 1'b0;
         off_q      <= 1'b0;
         all_q      <= 1'b0;
      end else begin
         err_q      <= err_now;
         off_q      <= any_off;
         all_q      <= all_off;
         irq_stat_q <= irq_stat_d;
         if (s_axi_awvalid && !aw_held_q) begin
            aw_held_q <= 1'b1;
            awaddr_q  <= s_axi_awaddr;
         end
         if (s_axi_wvalid && !w_held_q) begin
            w_held_q <= 1'b1;
            wdata_q  <= s_axi_wdata;
            wstrb_q  <= s_axi_wstrb;
         end
         if (wr_go) begin
            aw_held_q <= 1'b0;
            w_held_q  <= 1'b0;
            bvalid_q  <= 1'b1;
            bresp_q   <= addr_ok_w ? 2'b00 : 2'b11;
         end else if (s_axi_bready) begin
            bvalid_q <= 1'b0;
         end
         if (wr_ctrl)
            node_q <= wdata_q[6:0];
         if (wr_mask)
            irq_mask_q <= wdata_q[`FMSD_IRQ_W-1:0];
         if (ar_go) begin
            rvalid_q <= 1'b1;
            rresp_q  <= addr_ok_r ? 2'b00 : 2'b11;
            case (s_axi_araddr)
               `FMSD_OFF_CTRL:     rdata_q <= {25'h0, node_q};
               `FMSD_OFF_STATUS:   rdata_q <= status_w;
               `FMSD_OFF_IRQ_STAT: rdata_q <= {29'h0, irq_stat_q};
               `FMSD_OFF_IRQ_MASK: rdata_q <= {29'h0, irq_mask_q};
               default:            rdata_q <= 32'h0;
            endcase
         end else if (s_axi_rready) begin
            rvalid_q <= 1'b0;
         end
      end
   end

   assign s_axi_awready = !aw_held_q;
   assign s_axi_wready  = !w_held_q;
   assign s_axi_bvalid  = bvalid_q;
   assign s_axi_bresp   = bresp_q;
   assign s_axi_arready = !rvalid_q;
   assign s_axi_rvalid  = rvalid_q;
   assign s_axi_rdata   = rdata_q;
   assign s_axi_rresp   = rresp_q;
   assign disp_code     = disp_q;
   assign led_green     = green_q;
   assign led_red       = red_q;
   assign irq           = |(irq_stat_q & irq_mask_q);

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   green_conn_a: assert property (!fault.cfg_empty && !any_off |=> led_green && !led_red)
      else $error("green not steady while connected");
   cfg_flash_a: assert property (fault.cfg_empty
      |=> !led_red && (led_green == $past(flash_q)))
      else $error("empty configuration not flashing green");
   all_red_a: assert property (!fault.cfg_empty && all_off |=> led_red && !led_green)
      else $error("red not steady with all slaves offline");
   part_red_a: assert property (!fault.cfg_empty && any_off && !all_off |=> !led_green)
      else $error("green shown with a slave offline");
   run_addr_a: assert property (!err_now && plc_run && !any_off
      |=> disp_code == {1'b0, $past(node_q)})
      else $error("running display not node address");
   top_code_a: assert property (fault.dx_unit |=> disp_code == `FMSD_CODE_F7)
      else $error("highest fault code not shown");
   f1_code_a: assert property (fault == 10'b0000001000 |=> disp_code == `FMSD_CODE_F1)
      else $error("empty configuration code wrong");
   hold_phase_a: assert property (seq_mode && !restart && hold_q != '0
      |=> $stable(phase_q))
      else $error("display code changed before hold ended");
   flash_tick_a: assert property (flash_cnt_q != '0 |=> $stable(flash_q))
      else $error("flash toggled early");
   stop_seq_a: assert property (seq_mode && !restart && hold_end
      && phase_q == fmsd_pkg::PH_SLV && !plc_run |=> phase_q == fmsd_pkg::PH_STOP)
      else $error("stopped offline sequence did not return to 80");

   // sequence codes
   stop_code_a: assert property (!hi_fault && seq_mode && !restart
      && phase_q == fmsd_pkg::PH_STOP |=> disp_code == `FMSD_CODE_STOP)
      else $error("stop phase not showing 80");
   restart_a: assert property (restart && seq_mode && !hi_fault && !plc_run
      |=> disp_code == `FMSD_CODE_STOP)
      else $error("stopped sequence did not start with 80");
   own_code_a: assert property (!hi_fault && seq_mode && !restart
      && phase_q == fmsd_pkg::PH_OWN |=> disp_code == $past(node_code))
      else $error("own phase not showing node address");
   e2_code_a: assert property (!hi_fault && seq_mode && !restart
      && phase_q == fmsd_pkg::PH_E2 |=> disp_code == `FMSD_CODE_E2)
      else $error("offline phase not showing E2");
   slave_off_a: assert property (!hi_fault && seq_mode && !restart
      && phase_q == fmsd_pkg::PH_SLV |-> off_v[slave_idx])
      else $error("shown slave is not offline");
   run_off_a: assert property (seq_mode && plc_run && !restart && hold_end
      && phase_q == fmsd_pkg::PH_E2 |=> phase_q == fmsd_pkg::PH_SLV)
      else $error("E2 not followed by slave address");

   // fault codes, node address and flash toggle
   lo_code_a: assert property (!hi_fault && !seq_mode && fault.no_map
      |=> disp_code == `FMSD_CODE_F2)
      else $error("mapping fault code not shown");
   hi_fault_a: assert property (hi_fault |=> disp_code[7:4] == 4'hf)
      else $error("hardware fault not shown as error code");
   node_range_a: assert property (!err_now && !seq_mode |=> !disp_code[7])
      else $error("node address out of range");
   flash_flip_a: assert property (flash_cnt_q == '0 |=> flash_q != $past(flash_q))
      else $error("flash did not toggle at period end");

   // register and interrupt side
   irq_set_a: assert property (irq_ev != '0
      |=> (irq_stat_q & $past(irq_ev)) == $past(irq_ev))
      else $error("interrupt event not latched");
   w1c_a: assert property (wr_stat && irq_ev == '0
      |=> (irq_stat_q & $past(wdata_q[`FMSD_IRQ_W-1:0])) == '0)
      else $error("status bit not cleared by write");
   mask_wr_a: assert property (wr_mask |=> irq_mask_q == $past(wdata_q[`FMSD_IRQ_W-1:0]))
      else $error("mask write lost");
   node_wr_a: assert property (wr_ctrl |=> node_q == $past(wdata_q[6:0]))
      else $error("node address write lost");
   wr_resp_a: assert property (wr_go |=> s_axi_bvalid)
      else $error("write response missing");
   rd_resp_a: assert property (ar_go |=> s_axi_rvalid)
      else $error("read response missing");
   bvalid_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("write response dropped early");
   rvalid_hold_a: assert property (s_axi_rvalid && !s_axi_rready
      |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read response dropped early");

   stop_alt_c: cover property (seq_mode && !plc_run && phase_q == fmsd_pkg::PH_OWN && hold_end);
   run_off_c:  cover property (seq_mode && plc_run && phase_q == fmsd_pkg::PH_SLV && hold_end);
   slave_c:    cover property (disp_code == `FMSD_CODE_E2 ##1 disp_code != `FMSD_CODE_E2);
   irq_c:      cover property (irq);
   wr_rd_c:    cover property (wr_go ##[1:5] ar_go);
endmodule : fmsd_top
`default_nettype wire
